// ### core/lcsl_core.sv
// shift word, output and control latches, status word of a 24 sink driver
// assumes: host clocks serial data on serial_clk_in, raises the strobe
// at least one link period after the last serial edge
//
// Notes on behaviour
// - two writable latches, on-off and control, each 24 bits wide
// - strobe rise with route bit 0 copies low 24 bits to on-off latch
// - strobe rise with route bit 1 copies low 24 bits to control latch
// - on-off bit 1 enables its sink, 0 disables it
// - latches cleared to zero at reset; host writes both before enabling
// - control bits 6..0 are the red group brightness code
// - control bits 13..7 are the green group brightness code
// - control bits 20..14 are the blue group brightness code
// - detect select 0..3 picks open detection at four thresholds
// - detect select 4..7 picks short detection at four thresholds
// - each group code gives 128 steps from zero to full current
// - a 25-bit status word holds detection results and overtemp flag
// - route 0 strobe loads status into shift word after on-off copy
// - route 1 strobe never loads status into shift word
// - after a status load, strobes ignored until new data shifted in
// - status bits leave on serial output, one per serial clock rise
// - blanking high forces all sinks off; low lets latch bits through
// - code changes act at once; current is max times code over 127
// - detection bit set only for sinks programmed on
// - holder captures results at blank rise; strobe moves them out
`timescale 1ns/10ps

module lcsl_core
  import lcsl_pkg::*;
#(
  parameter int unsigned MAX_UA = MAX_CURRENT_UA
) (
  // system clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // serial link
  input wire logic serial_clk_in,
  input wire logic serial_data_in_in,
  input wire logic latch_strobe_in,
  output logic serial_data_out,
  // output control
  input wire logic blank_in,
  output logic [CHAN_N-1:0] sink_on_out,
  output lcsl_ctrl_t ctrl_out,
  output logic [GROUP_N-1:0][CURRENT_W-1:0] group_current_ua_out,
  // detection comparators and temperature
  input wire logic [CHAN_N-1:0] open_led_detect_in,
  input wire logic [CHAN_N-1:0] shorted_led_detect_in,
  input wire logic overtemp_flag_in
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic link_bit;
  logic link_toggle;
  lcsl_pins_t pins_raw;
  lcsl_pins_t pins_s1;
  lcsl_pins_t pins_s2;
  logic toggle_seen;
  logic strobe_d;
  logic blank_d;
  logic shift_evt;
  logic strobe_rise;
  logic blank_rise;
  logic accept;
  logic route;
  logic [SHIFT_W-1:0] serial_shift_word;
  logic [CHAN_N-1:0] output_enable_latch;
  lcsl_ctrl_t brightness_detect_latch;
  logic [CHAN_N-1:0] detect_live;
  logic [CHAN_N-1:0] detect_holder;
  logic overtemp_holder;
  lcsl_status_t status_word;
  lcsl_strobe_state_t strobe_state;
  lcsl_strobe_state_t next_strobe_state;
  logic [GROUP_N-1:0][CODE_W-1:0] group_brightness_code;

  // ------------------------------------------------------------
  // link domain front end
  // ------------------------------------------------------------
  lcsl_link_rx u_link_rx (
    .serial_clk_in(serial_clk_in),
    .rst_b_in(rst_b_in),
    .serial_data_in_in(serial_data_in_in),
    .bit_out(link_bit),
    .toggle_out(link_toggle)
  );

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  assign pins_raw = '{
    toggle: link_toggle,
    strobe: latch_strobe_in,
    blank: blank_in,
    overtemp: overtemp_flag_in,
    shorted: shorted_led_detect_in,
    open: open_led_detect_in
  };

  // first stage is read by the second stage only; no reset, so the
  // toggle copy keeps tracking a link that stays idle across a reset
  always_ff @(posedge sys_clk_in) begin
    pins_s1 <= pins_raw;
    pins_s2 <= pins_s1;
  end

  // the toggle history follows the link during reset so that a link
  // clock idle through reset yields no phantom shift afterwards
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      toggle_seen <= pins_s2.toggle;
      strobe_d <= 1'b0;
      blank_d <= 1'b0;
    end else begin
      toggle_seen <= pins_s2.toggle;
      strobe_d <= pins_s2.strobe;
      blank_d <= pins_s2.blank;
    end
  end

  assign shift_evt = pins_s2.toggle ^ toggle_seen;
  assign strobe_rise = pins_s2.strobe & ~strobe_d;
  assign blank_rise = pins_s2.blank & ~blank_d;
  assign route = serial_shift_word[ROUTE_BIT];
  assign accept = strobe_rise & (strobe_state == LAT_ARMED);

  // ------------------------------------------------------------
  // strobe acceptance state
  // ------------------------------------------------------------
  always_comb begin
    next_strobe_state = strobe_state;
    case (strobe_state)
      LAT_ARMED: begin
        if (accept && !route && !shift_evt) begin
          next_strobe_state = LAT_SPENT;
        end
      end
      LAT_SPENT: begin
        if (shift_evt) begin
          next_strobe_state = LAT_ARMED;
        end
      end
      default: begin
        next_strobe_state = LAT_ARMED;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      strobe_state <= LAT_ARMED;
    end else begin
      strobe_state <= next_strobe_state;
    end
  end

  // ------------------------------------------------------------
  // detection holder and status word
  // ------------------------------------------------------------
  always_comb begin
    if (brightness_detect_latch.dsel >= DSEL_SHORT_MIN) begin
      detect_live = pins_s2.shorted;
    end else begin
      detect_live = pins_s2.open;
    end
  end

  // transparent while blanking is low, frozen from its rising edge
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      detect_holder <= '0;
    end else if (!pins_s2.blank) begin
      detect_holder <= detect_live & output_enable_latch;
    end
  end

  // set wins over the clear done by a status load
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      overtemp_holder <= 1'b0;
    end else if (pins_s2.overtemp) begin
      overtemp_holder <= 1'b1;
    end else if (accept && !route) begin
      overtemp_holder <= 1'b0;
    end
  end

  // gated by the on-off pattern being latched on this very strobe
  assign status_word = '{
    overtemp: overtemp_holder,
    detect: detect_holder & serial_shift_word[CHAN_N-1:0]
  };

  // ------------------------------------------------------------
  // shift word
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      serial_shift_word <= SHIFT_RST;
    end else if (accept && !route) begin
      serial_shift_word <= status_word;
    end else if (shift_evt) begin
      serial_shift_word <= {serial_shift_word[SHIFT_W-2:0], link_bit};
    end
  end

  assign serial_data_out = serial_shift_word[SHIFT_W-1];

  // ------------------------------------------------------------
  // data latches
  // ------------------------------------------------------------
  // cleared at reset so sinks stay dark until the host writes them
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      output_enable_latch <= ONOFF_RST;
    end else if (accept && !route) begin
      output_enable_latch <= serial_shift_word[CHAN_N-1:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      brightness_detect_latch <= CTRL_RST;
    end else if (accept && route) begin
      brightness_detect_latch <= serial_shift_word[CHAN_N-1:0];
    end
  end

  // ------------------------------------------------------------
  // sink enables and group currents
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      sink_on_out <= '0;
    end else if (pins_s2.blank) begin
      sink_on_out <= '0;
    end else begin
      sink_on_out <= output_enable_latch;
    end
  end

  assign ctrl_out = brightness_detect_latch;
  assign group_brightness_code[0] = brightness_detect_latch.red;
  assign group_brightness_code[1] = brightness_detect_latch.green;
  assign group_brightness_code[2] = brightness_detect_latch.blue;

  // a plain divide trades area for an exact ratio to full scale
  generate
    for (genvar g = 0; g < GROUP_N; g++) begin : g_current
      always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
          group_current_ua_out[g] <= '0;
        end else begin
          group_current_ua_out[g] <= CURRENT_W'((32'(MAX_UA) *
            32'(group_brightness_code[g])) / 32'(CODE_FULL));
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence seq_load_onoff;
    accept && !route;
  endsequence

  sequence seq_load_ctrl;
    accept && route;
  endsequence

  sequence seq_spent_strobe;
    strobe_state == LAT_SPENT && strobe_rise && !shift_evt;
  endsequence

  a_onoff_copy: assert property (
    seq_load_onoff |=>
      output_enable_latch == $past(serial_shift_word[CHAN_N-1:0]))
    else $error("on-off latch missed its copy");

  a_ctrl_copy: assert property (
    seq_load_ctrl |=>
      brightness_detect_latch == $past(serial_shift_word[CHAN_N-1:0])
      && $stable(output_enable_latch))
    else $error("control latch missed its copy");

  a_status_load: assert property (
    seq_load_onoff |=> serial_shift_word == $past(status_word)
      && strobe_state == LAT_SPENT)
    else $error("status word not loaded after on-off copy");

  a_no_status_ctrl: assert property (
    seq_load_ctrl and !shift_evt |=> $stable(serial_shift_word))
    else $error("status loaded on a control write");

  a_spent_ignored: assert property (
    seq_spent_strobe |=> $stable(output_enable_latch)
      && $stable(brightness_detect_latch) && $stable(serial_shift_word))
    else $error("strobe acted while status was pending");

  a_rearm_shift: assert property (
    strobe_state == LAT_SPENT && shift_evt |=> strobe_state == LAT_ARMED)
    else $error("new serial data did not rearm the strobe");

  a_serial_shift: assert property (
    shift_evt && !accept |=> serial_shift_word ==
      {$past(serial_shift_word[SHIFT_W-2:0]), $past(link_bit)})
    else $error("shift word did not advance by one bit");

  a_blank_off: assert property (
    pins_s2.blank |=> sink_on_out == '0)
    else $error("sink on while blanked");

  a_sink_follow: assert property (
    !pins_s2.blank [*2] |=> sink_on_out == $past(output_enable_latch))
    else $error("sink does not follow its latch bit");

  a_detect_gated: assert property (
    seq_load_onoff |=>
      (serial_shift_word[CHAN_N-1:0] & ~output_enable_latch) == '0)
    else $error("detection reported for a sink that is off");

  a_holder_frozen: assert property (
    pins_s2.blank |=> $stable(detect_holder))
    else $error("holder changed while blanking is high");

  a_holder_capture: assert property (
    blank_rise |-> detect_holder == $past(detect_live & output_enable_latch))
    else $error("holder missed the blanking rise");

  a_code_fields: assert property (
    ctrl_out.red == brightness_detect_latch[RED_LSB +: CODE_W]
      && ctrl_out.green == brightness_detect_latch[GREEN_LSB +: CODE_W]
      && ctrl_out.blue == brightness_detect_latch[BLUE_LSB +: CODE_W]
      && ctrl_out.dsel == brightness_detect_latch[DSEL_LSB +: DSEL_W])
    else $error("control field layout broken");

  a_current_full: assert property (
    seq_load_ctrl ##1 brightness_detect_latch.red == CODE_FULL |=>
      group_current_ua_out[0] == CURRENT_W'(MAX_UA))
    else $error("full code did not give full current");

  a_overtemp_status: assert property (
    seq_load_onoff |=>
      serial_shift_word[OVERTEMP_BIT] == $past(overtemp_holder))
    else $error("overtemp flag not in status word");

endmodule // lcsl_core

// ### core/lcsl_link_rx.sv
// serial clock side: samples the serial input and flags each rising edge
// assumes the serial clock may stop between frames; data held meanwhile
`timescale 1ns/10ps

module lcsl_link_rx
  import lcsl_pkg::*;
(
  // link clock and reset from the system side
  input wire logic serial_clk_in,
  input wire logic rst_b_in,
  // serial data
  input wire logic serial_data_in_in,
  // to system domain
  output logic bit_out,
  output logic toggle_out
);

  logic rst_s1;
  logic rst_s2;

  // ------------------------------------------------------------
  // reset brought into the link domain
  // ------------------------------------------------------------
  always_ff @(posedge serial_clk_in) begin
    rst_s1 <= rst_b_in;
    rst_s2 <= rst_s1;
  end

  // ------------------------------------------------------------
  // bit capture; the bit holds for a whole link period, so the
  // system side may read it once it sees the toggle move
  // ------------------------------------------------------------
  always_ff @(posedge serial_clk_in) begin
    if (!rst_s2) begin
      bit_out <= 1'b0;
      toggle_out <= 1'b0;
    end else begin
      bit_out <= serial_data_in_in;
      toggle_out <= ~toggle_out;
    end
  end

endmodule // lcsl_link_rx

// ### core/lcsl_pkg.sv
// shared constants and carrier types of the led sink serial latch block
// assumes nothing of its surroundings; imported whole by every module

package lcsl_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int CHAN_N = 24;
  localparam int SHIFT_W = 25;
  localparam int ROUTE_BIT = 24;
  localparam int CODE_W = 7;
  localparam int DSEL_W = 3;
  localparam int GROUP_N = 3;
  localparam int CURRENT_W = 16;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int RED_LSB = 0;
  localparam int GREEN_LSB = 7;
  localparam int BLUE_LSB = 14;
  localparam int DSEL_LSB = 21;
  localparam int OVERTEMP_BIT = 24;

  // ------------------------------------------------------------
  // codes and reset values
  // ------------------------------------------------------------
  localparam logic [DSEL_W-1:0] DSEL_SHORT_MIN = 3'h4;
  localparam logic [CODE_W-1:0] CODE_FULL = 7'h7F;
  localparam logic [CHAN_N-1:0] ONOFF_RST = 24'h000000;
  localparam logic [CHAN_N-1:0] CTRL_RST = 24'h000000;
  localparam logic [SHIFT_W-1:0] SHIFT_RST = 25'h0000000;
  localparam int MAX_CURRENT_UA = 35000;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [DSEL_W-1:0] dsel;
    logic [CODE_W-1:0] blue;
    logic [CODE_W-1:0] green;
    logic [CODE_W-1:0] red;
  } lcsl_ctrl_t;

  typedef struct packed {
    logic overtemp;
    logic [CHAN_N-1:0] detect;
  } lcsl_status_t;

  typedef struct packed {
    logic toggle;
    logic strobe;
    logic blank;
    logic overtemp;
    logic [CHAN_N-1:0] shorted;
    logic [CHAN_N-1:0] open;
  } lcsl_pins_t;

  typedef enum logic [1:0] {
    LAT_ARMED = 2'b01,
    LAT_SPENT = 2'b10
  } lcsl_strobe_state_t;

endpackage

// ### verif/lcsl_core_tb.sv
// self-checking bench of the shift word, latches and status word
// assumes the host model paces all link traffic
`timescale 1ns/10ps

module lcsl_core_tb
  import lcsl_pkg::*;
;
  localparam int MAX_UA = 35000;
  localparam int CYCLE_LIMIT = 20000;
  localparam logic [CHAN_N-1:0] ON_A = 24'hA50F3C;
  localparam logic [CHAN_N-1:0] ON_B = 24'hF0F0F3;
  localparam logic [CHAN_N-1:0] OPEN_P = 24'h3355AA;
  localparam logic [CHAN_N-1:0] SHORT_P = 24'hCC0F55;

  logic sys_clk_in;
  logic rst_b_in;
  logic serial_clk;
  logic serial_data;
  logic strobe;
  logic sdo;
  logic blank;
  logic overtemp;
  logic [CHAN_N-1:0] open_det;
  logic [CHAN_N-1:0] short_det;
  logic [CHAN_N-1:0] sink_on;
  lcsl_ctrl_t ctrl;
  logic [GROUP_N-1:0][CURRENT_W-1:0] cur;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_cycles = 0;

  lcsl_core #(.MAX_UA(MAX_UA)) u_lcsl_core (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .serial_clk_in(serial_clk), .serial_data_in_in(serial_data),
    .latch_strobe_in(strobe), .serial_data_out(sdo),
    .blank_in(blank), .sink_on_out(sink_on), .ctrl_out(ctrl),
    .group_current_ua_out(cur), .open_led_detect_in(open_det),
    .shorted_led_detect_in(short_det), .overtemp_flag_in(overtemp)
  );

  lcsl_host_model u_lcsl_host_model (
    .sys_clk_in(sys_clk_in), .dev_data_in(sdo),
    .host_clk_out(serial_clk), .host_data_out(serial_data),
    .host_strobe_out(strobe)
  );

  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end

  always @(posedge sys_clk_in) begin
    n_cycles <= n_cycles + 1;
    if (n_cycles == CYCLE_LIMIT) begin
      n_mismatch = n_mismatch + 1;
      $display("BAD %0t run too long", $time);
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  function automatic lcsl_ctrl_t mk_ctrl(input logic [DSEL_W-1:0] d);
    return '{dsel: d, blue: 7'h01, green: 7'h00, red: CODE_FULL};
  endfunction

  function automatic logic [SHIFT_W-1:0] exp_status(input logic ot,
      input logic [DSEL_W-1:0] d, input logic [CHAN_N-1:0] on);
    return {ot, (d < DSEL_SHORT_MIN ? OPEN_P : SHORT_P) & on};
  endfunction

  task automatic put_word(input logic [SHIFT_W-1:0] w,
                          output logic [SHIFT_W-1:0] rx);
    u_lcsl_host_model.xfer(w, rx);
    u_lcsl_host_model.pulse_strobe();
  endtask

  task automatic t_reset();
    check(32'(sink_on), 32'h0, "sinks at reset");
    check(32'(ctrl), 32'h0, "ctrl at reset");
    check(32'(sdo), 32'h0, "serial out at reset");
  endtask

  task automatic t_onoff();
    logic [SHIFT_W-1:0] rx;
    put_word({1'b0, ON_A}, rx);
    check(32'(sink_on), 32'(ON_A), "on-off latch");
    check(32'(ctrl), 32'h0, "ctrl untouched");
    blank <= 1'b1;
    repeat (6) @(posedge sys_clk_in);
    check(32'(sink_on), 32'h0, "blanked");
    blank <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
    check(32'(sink_on), 32'(ON_A), "unblanked");
  endtask

  task automatic t_ctrl();
    logic [SHIFT_W-1:0] rx;
    lcsl_ctrl_t c;
    c = mk_ctrl(3'h5);
    put_word({1'b1, c}, rx);
    check(32'(ctrl), 32'(c), "ctrl latch");
    check(32'(sink_on), 32'(ON_A), "on-off kept");
    check(32'(cur[0]), (MAX_UA * c.red) / 127, "red");
    check(32'(cur[1]), (MAX_UA * c.green) / 127, "green");
    check(32'(cur[2]), (MAX_UA * c.blue) / 127, "blue");
    u_lcsl_host_model.xfer({1'b0, ON_A}, rx);
    check(32'(rx), 32'({1'b1, c}), "no status load");
  endtask

  task automatic t_detect();
    logic [SHIFT_W-1:0] rx;
    lcsl_ctrl_t c;
    @(posedge sys_clk_in);
    open_det <= OPEN_P;
    short_det <= SHORT_P;
    put_word({1'b0, ON_B}, rx);
    for (int d = 0; d < 8; d++) begin
      c = mk_ctrl(3'(d));
      overtemp <= (d == 7);
      put_word({1'b1, c}, rx);
      check(32'(ctrl), 32'(c), "detect select");
      put_word({1'b0, ON_B}, rx);
      u_lcsl_host_model.xfer({1'b0, ON_B}, rx);
      check(32'(rx), 32'(exp_status(d == 7, 3'(d), ON_B)),
            "status word");
      check(32'(sink_on), 32'(ON_B), "pattern kept");
    end
  endtask

  task automatic t_refuse();
    logic [SHIFT_W-1:0] rx;
    @(posedge sys_clk_in);
    overtemp <= 1'b0;
    put_word({1'b0, ON_B}, rx);
    u_lcsl_host_model.pulse_strobe();
    check(32'(sink_on), 32'(ON_B), "strobe ignored");
    check(32'(ctrl), 32'(mk_ctrl(3'h7)), "ctrl kept");
    u_lcsl_host_model.xfer({1'b0, ON_B}, rx);
    check(32'(rx), 32'(exp_status(1'b1, 3'h7, ON_B)), "held flag");
  endtask

  task automatic t_blank();
    logic [SHIFT_W-1:0] rx;
    // results settle in the holder three cycles after the detect inputs while blanking is low
    repeat (130) @(posedge sys_clk_in);
    blank <= 1'b1;
    repeat (6) @(posedge sys_clk_in);
    short_det <= ~SHORT_P;
    put_word({1'b0, ON_B}, rx);
    check(32'(sink_on), 32'h0, "blank forces off");
    u_lcsl_host_model.xfer({1'b0, ON_B}, rx);
    check(32'(rx), 32'({1'b0, SHORT_P & ON_B}), "frozen holder");
    @(posedge sys_clk_in);
    blank <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
    check(32'(sink_on), 32'(ON_B), "blank released");
  endtask

  initial begin
    rst_b_in = 1'b0;
    blank = 1'b0;
    overtemp = 1'b0;
    open_det = '0;
    short_det = '0;
    // reset spans several link edges so the link side resets as well
    u_lcsl_host_model.flush(4);
    @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    // the link side leaves reset only on two of its own edges
    u_lcsl_host_model.flush(2);
    t_reset();
    t_onoff();
    t_ctrl();
    t_detect();
    t_refuse();
    t_blank();
    print_verdict();
  end
endmodule // lcsl_core_tb

// ### verif/lcsl_host_model.sv
// host model: drives the serial link and latch strobe of the sink driver
// assumes one bench process calls its tasks, starting on a system edge
`timescale 1ns/10ps

module lcsl_host_model
  import lcsl_pkg::*;
#(
  parameter int HALF_NS = 24
) (
  // system clock, paces the strobe
  input wire logic sys_clk_in,
  // device serial output
  input wire logic dev_data_in,
  // link pins toward the device
  output logic host_clk_out,
  output logic host_data_out,
  output logic host_strobe_out
);
  initial begin
    host_clk_out = 1'b0;
    host_data_out = 1'b0;
    host_strobe_out = 1'b0;
  end

  // a few link edges under reset so the link side leaves reset cleanly
  task automatic flush(input int n);
    repeat (n) begin
      #(HALF_NS) host_clk_out = 1'b1;
      #(HALF_NS) host_clk_out = 1'b0;
    end
  endtask

  // one frame, route bit first; device output taken just before each rise
  task automatic xfer(input logic [SHIFT_W-1:0] tx,
                      output logic [SHIFT_W-1:0] rx);
    #3;
    for (int i = SHIFT_W - 1; i >= 0; i--) begin
      host_data_out = tx[i];
      #(HALF_NS);
      rx[i] = dev_data_in;
      host_clk_out = 1'b1;
      #(HALF_NS);
      host_clk_out = 1'b0;
    end
    // no pull on the line, so a released line must not look stale
    host_data_out = ~tx[0];
  endtask

  // strobe well clear of the last link edge, wide enough to be synced
  task automatic pulse_strobe();
    repeat (8) @(posedge sys_clk_in);
    host_strobe_out <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    host_strobe_out <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
  endtask
endmodule // lcsl_host_model
